// ==== hw/asrp_defines.svh ====
// Purpose: constants of the serial readout port
// Assumes: byte addressed Avalon-MM slave, 32-bit data
// Notes: every offset, the status and mask field positions and reset values, and the bit count live here
`ifndef ASRP_DEFINES_SVH
`define ASRP_DEFINES_SVH

// ****************************************
// register map (byte addresses)
// ****************************************
`define ASRP_ADDR_W 4
`define ASRP_OFS_STATUS 4'h0
`define ASRP_OFS_MASK 4'h4
`define ASRP_OFS_RESULT 4'h8
`define ASRP_OFS_STATE 4'hC

// ****************************************
// status / mask fields
// ****************************************
`define ASRP_EVT_W 3
`define ASRP_EVT_DONE 0
`define ASRP_EVT_ERR 1
`define ASRP_EVT_LATCH 2
`define ASRP_STATUS_RST 3'h0
`define ASRP_MASK_RST 3'h0

// ****************************************
// serial word and timing
// ****************************************
`define ASRP_DATA_W 16
`define ASRP_CNT_W 5
`define ASRP_BITS 5'h10
`define ASRP_CLK_HZ 10000000
`define ASRP_INT_SCLK_HZ 500000
// four ticks per internal bit clock period
`define ASRP_TICK_DIV (`ASRP_CLK_HZ / (4 * `ASRP_INT_SCLK_HZ))
`define ASRP_DIV_W 8
`define ASRP_SYNC_W 8

`endif

// ==== hw/asrp_pkg.sv ====
// Purpose: shared types of the serial readout port
// Assumes: nothing beyond the defines header
// Notes: read sequencer states
package asrp_pkg;
   typedef enum logic [1:0] {
      ASRP_IDLE,
      ASRP_INT_RUN,
      ASRP_EXT_RUN
   } asrp_state_t;
endpackage

// ==== hw/asrp_sync.sv ====
// Purpose: two flip-flop synchroniser for a group of pin inputs
// Assumes: bits are independent levels
// Notes: the first stage is read only by the second
`timescale 1ns/1ns
module asrp_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         sync_o <= '0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule

// ==== hw/asrp_core.sv ====
// Purpose: serial readout port of a 16-bit converter, shared with parallel bits 7..9
// Assumes: result and busy come from the converter core on clk_i
// Notes: pins are synchronised; external bit clock is oversampled by clk_i
`timescale 1ns/1ns
`include "asrp_defines.svh"
module asrp_core (
   input wire logic clk_i,
   input wire logic rst_n_i,
   // converter core
   input wire logic [15:0] result_i,
   input wire logic result_valid_i,
   input wire logic conv_busy_i,
   // configuration pins
   input wire logic port_select_i,
   input wire logic clock_source_select_i,
   input wire logic clock_invert_i,
   input wire logic output_coding_i,
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   // shared pin: parallel bit 7 or readmode_chain_pin
   input wire logic parallel_bit_seven_i,
   output logic parallel_bit_seven_o,
   output logic parallel_bit_seven_oe_o,
   // shared pin: parallel bit 8 or serial_data_out
   output logic parallel_bit_eight_o,
   output logic parallel_bit_eight_oe_o,
   // shared pin: parallel bit 9 or serial bit clock
   input wire logic parallel_bit_nine_i,
   output logic parallel_bit_nine_o,
   output logic parallel_bit_nine_oe_o,
   output logic incomplete_read_flag_o,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq_o
);
   import asrp_pkg::*;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [15:0] code_result(input logic [15:0] r, input logic straight);
      code_result = straight ? r : {~r[15], r[14:0]};
   endfunction

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [`ASRP_SYNC_W-1:0] pins_s;
   logic ser_s, ext_s, inv_s, coding_s, cs_s, rd_s, pin7_s, sclk_s;

   asrp_sync #(.WIDTH(`ASRP_SYNC_W)) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      // chip select and read enter inverted so that the cleared stages read as deselected
      .async_i({port_select_i, clock_source_select_i, clock_invert_i, output_coding_i,
                ~cs_n_i, ~rd_n_i, parallel_bit_seven_i, parallel_bit_nine_i}),
      .sync_o(pins_s)
   );
   assign {ser_s, ext_s, inv_s, coding_s, cs_s, rd_s, pin7_s, sclk_s} = pins_s;

   logic bus_en;
   logic early_read, chain_in;
   assign bus_en = cs_s && rd_s;
   assign early_read = ser_s && !ext_s && pin7_s;
   assign chain_in = ser_s && ext_s && pin7_s;

   // ****************************************
   // result latch
   // ****************************************
   logic [15:0] held_q;
   logic [15:0] coded;
   assign coded = code_result(result_i, coding_s);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         held_q <= 16'h0000;
      end else if (result_valid_i) begin
         held_q <= coded;
      end
   end

   // ****************************************
   // edge detection
   // ****************************************
   logic sclk_prev_q, busy_prev_q, bus_en_prev_q;
   logic ext_rise, ext_fall, ext_active, busy_rise, bus_en_rise;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_prev_q <= 1'b0;
         busy_prev_q <= 1'b0;
         bus_en_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_s;
         busy_prev_q <= conv_busy_i;
         bus_en_prev_q <= bus_en;
      end
   end

   // chip select low is required before an external edge counts
   assign ext_rise = sclk_s && !sclk_prev_q && cs_s;
   assign ext_fall = !sclk_s && sclk_prev_q && cs_s;
   assign ext_active = inv_s ? ext_fall : ext_rise;
   assign busy_rise = conv_busy_i && !busy_prev_q;
   assign bus_en_rise = bus_en && !bus_en_prev_q;

   // ****************************************
   // internal bit clock divider
   // ****************************************
   logic [`ASRP_DIV_W-1:0] div_q;
   logic tick;
   assign tick = (div_q == `ASRP_DIV_W'(`ASRP_TICK_DIV - 1));

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_q <= '0;
      end else if (tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // ****************************************
   // read sequencer
   // ****************************************
   asrp_state_t state_q;
   logic [15:0] shift_q;
   logic [`ASRP_CNT_W-1:0] cnt_q;
   logic [1:0] phase_q;
   logic sclk_out_q;
   logic ev_done, ev_err;
   logic int_start, ext_abort;

   // the old word goes out at conversion start, a fresh one at conversion end
   assign int_start = ser_s && !ext_s && bus_en &&
                      (early_read ? busy_rise : result_valid_i);
   assign ext_abort = result_valid_i && (cnt_q < `ASRP_BITS);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= ASRP_IDLE;
         shift_q <= 16'h0000;
         cnt_q <= '0;
         phase_q <= 2'h0;
         sclk_out_q <= 1'b0;
         ev_done <= 1'b0;
         ev_err <= 1'b0;
      end else begin
         ev_done <= 1'b0;
         ev_err <= 1'b0;
         unique case (state_q)
            ASRP_IDLE: begin
               cnt_q <= '0;
               phase_q <= 2'h0;
               sclk_out_q <= 1'b0;
               if (int_start) begin
                  shift_q <= early_read ? held_q : coded;
                  state_q <= ASRP_INT_RUN;
               end else if (ser_s && ext_s && bus_en_rise) begin
                  shift_q <= held_q;
                  state_q <= ASRP_EXT_RUN;
               end
            end
            ASRP_INT_RUN: begin
               if (!ser_s || !bus_en) begin
                  state_q <= ASRP_IDLE;
               end else if (tick) begin
                  phase_q <= phase_q + 1'b1;
                  sclk_out_q <= (phase_q == 2'h0) || (phase_q == 2'h1);
                  if (phase_q == 2'h3) begin
                     // data moves mid low phase, clear of both clock edges
                     if (cnt_q == `ASRP_BITS - 1'b1) begin
                        ev_done <= 1'b1;
                        state_q <= ASRP_IDLE;
                     end else begin
                        cnt_q <= cnt_q + 1'b1;
                        shift_q <= {shift_q[14:0], 1'b0};
                     end
                  end
               end
            end
            ASRP_EXT_RUN: begin
               if (!ser_s || !ext_s || !bus_en) begin
                  state_q <= ASRP_IDLE;
               end else if (ext_abort) begin
                  // unfinished word is dropped; a new read needs a new select
                  ev_err <= 1'b1;
                  state_q <= ASRP_IDLE;
               end else if (ext_active) begin
                  // chain bits enter at the LSB, behind the own 16 bits
                  shift_q <= {shift_q[14:0], chain_in};
                  if (cnt_q < `ASRP_BITS) begin
                     cnt_q <= cnt_q + 1'b1;
                  end
                  if (cnt_q == `ASRP_BITS - 1'b1) begin
                     ev_done <= 1'b1;
                  end
               end
            end
            default: begin
               state_q <= ASRP_IDLE;
            end
         endcase
      end
   end

   assign incomplete_read_flag_o = ev_err;

   // ****************************************
   // shared pin drivers
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         parallel_bit_seven_o <= 1'b0;
         parallel_bit_eight_o <= 1'b0;
         parallel_bit_nine_o <= 1'b0;
      end else if (!ser_s) begin
         parallel_bit_seven_o <= held_q[7];
         parallel_bit_eight_o <= held_q[8];
         parallel_bit_nine_o <= held_q[9];
      end else begin
         parallel_bit_seven_o <= 1'b0;
         parallel_bit_eight_o <= shift_q[15];
         parallel_bit_nine_o <= sclk_out_q;
      end
   end

   assign parallel_bit_seven_oe_o = !ser_s && bus_en;
   assign parallel_bit_eight_oe_o = bus_en;
   assign parallel_bit_nine_oe_o = bus_en && (!ser_s || !ext_s);

   // ****************************************
   // interrupt status and mask
   // ****************************************
   logic [`ASRP_EVT_W-1:0] status_q, mask_q, evt_set;
   logic ack_q;
   logic wr_take;
   assign evt_set = {result_valid_i, ev_err, ev_done};
   assign wr_take = avs_write && ack_q && avs_byteenable[0];

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status_q <= `ASRP_STATUS_RST;
      end else if (wr_take && (avs_address == `ASRP_OFS_STATUS)) begin
         // a new event in the clearing cycle survives
         status_q <= (status_q & ~avs_writedata[`ASRP_EVT_W-1:0]) | evt_set;
      end else begin
         status_q <= status_q | evt_set;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask_q <= `ASRP_MASK_RST;
      end else if (wr_take && (avs_address == `ASRP_OFS_MASK)) begin
         mask_q <= avs_writedata[`ASRP_EVT_W-1:0];
      end
   end

   assign irq_o = |(status_q & mask_q);

   // ****************************************
   // Avalon-MM slave: one wait cycle on every access
   // ****************************************
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_q <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         ack_q <= (avs_read || avs_write) && !ack_q;
         if (avs_read && !ack_q) begin
            unique case (avs_address)
               `ASRP_OFS_STATUS: avs_readdata <= {29'h0, status_q};
               `ASRP_OFS_MASK: avs_readdata <= {29'h0, mask_q};
               `ASRP_OFS_RESULT: avs_readdata <= {16'h0000, held_q};
               `ASRP_OFS_STATE: avs_readdata <= {22'h0, cnt_q, ser_s, ext_s,
                                                 state_q, conv_busy_i};
               default: avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// ==== testbench/asrp_chk.sv ====
// Purpose: port assertions of the serial readout port
// Assumes: a pin held for four cycles has passed its synchroniser
// Notes: bound to the core from the bench top file
`timescale 1ns/1ns
module asrp_chk (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic result_valid_i,
   input wire logic port_select_i,
   input wire logic clock_source_select_i,
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   input wire logic parallel_bit_seven_o,
   input wire logic parallel_bit_seven_oe_o,
   input wire logic parallel_bit_eight_o,
   input wire logic parallel_bit_eight_oe_o,
   input wire logic parallel_bit_nine_o,
   input wire logic parallel_bit_nine_oe_o,
   input wire logic incomplete_read_flag_o,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic irq_o
);
   // ****************
   // properties
   // ****************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   a_wait_one: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
      else $error("read kept waiting past one cycle");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 4'h2
      |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
   a_flag_pulse: assert property (incomplete_read_flag_o |=> !incomplete_read_flag_o)
      else $error("error flag longer than one cycle");
   a_flag_cause: assert property (incomplete_read_flag_o
      |-> $past(result_valid_i) || $past(result_valid_i, 2)) else $error("flag without result");
   a_par_drive: assert property ((!port_select_i && !cs_n_i && !rd_n_i) [*4]
      |-> parallel_bit_seven_oe_o && parallel_bit_eight_oe_o && parallel_bit_nine_oe_o)
      else $error("parallel bits not driven");
   a_ser_input: assert property (port_select_i [*4]
      |-> !parallel_bit_seven_oe_o && !parallel_bit_seven_o) else $error("chain pin driven");
   a_bus_off: assert property ((cs_n_i || rd_n_i) [*4]
      |-> !parallel_bit_eight_oe_o && !parallel_bit_seven_oe_o) else $error("bus on unselected");
   a_ext_clk_in: assert property ((port_select_i && clock_source_select_i) [*4]
      |-> !parallel_bit_nine_oe_o) else $error("external clock pin driven");
   a_int_clk_out: assert property ((port_select_i && !clock_source_select_i && !cs_n_i
      && !rd_n_i) [*4] |-> parallel_bit_nine_oe_o) else $error("internal clock not driven");
   a_int_stable: assert property ($changed(parallel_bit_nine_o) && port_select_i
      && $past(port_select_i, 4) && !clock_source_select_i && !$past(clock_source_select_i, 4)
      |-> $stable(parallel_bit_eight_o)) else $error("data moved on a clock edge");
   c_abort: cover property (incomplete_read_flag_o);
   c_irq: cover property ($rose(irq_o));
   c_int_clk: cover property (port_select_i && !clock_source_select_i && $rose(parallel_bit_nine_o));
endmodule

// ==== testbench/asrp_host.sv ====
// Purpose: host controller model on the far side of the serial port
// Assumes: bit clock period 800 ns, phase unrelated to the block clock
// Notes: word holds the last whole serial word, done_e marks it
`timescale 1ns/1ns
module asrp_host (
   input wire logic clk_i,
   input wire logic sdo_i,
   input wire logic sck_i,
   input wire logic inv_i,
   input wire logic int_i,
   output logic cs_n_o = 1,
   output logic rd_n_o = 1,
   output logic sclk_o = 0,
   output logic chain_o = 0
);
   logic [31:0] word;
   logic [17:0] g;
   int n_int = 0;
   event done_e;
   task automatic en(input logic b, input logic c);
      @(posedge clk_i);
      cs_n_o <= b;
      rd_n_o <= b;
      chain_o <= c;
   endtask
   // clock stands at its idle level outside frames
   task automatic frame(input int n, input logic c);
      sclk_o = inv_i;
      chain_o = c;
      #837;
      cs_n_o = 0;
      rd_n_o = 0;
      #1037;
      g[17] = sdo_i;
      for (int i = 1; i < n; i++) begin
         sclk_o = ~inv_i;
         #400;
         sclk_o = inv_i;
         g[17 - i] = sdo_i;
         #400;
      end
      cs_n_o = 1;
      rd_n_o = 1;
      #800;
      if (n == 18) begin
         word = {14'h0, g};
         ->done_e;
      end
   endtask
   always @(posedge sck_i) if (int_i && !cs_n_o) begin
      g = {g[16:0], sdo_i};
      n_int++;
      if (n_int == 16) begin
         n_int = 0;
         word = {16'h0, g[15:0]};
         ->done_e;
      end
   end
endmodule

// ==== testbench/asrp_core_tb.sv ====
// Purpose: self-checking bench of the serial readout port
// Assumes: the host model owns select, read, bit clock and chain pins
// Notes: expected words queue up and are checked in arrival order
`timescale 1ns/1ns
`include "asrp_defines.svh"
module asrp_core_tb;
   logic clk_i = 0, rst_n_i = 0, result_valid_i = 0, conv_busy_i = 0, port_select_i = 0;
   logic clock_source_select_i = 1, clock_invert_i = 0, output_coding_i = 1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 0, avs_write = 0, avs_waitrequest, irq_o, rd_err;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, v, s = 32'hC87A;
   logic [15:0] result_i = 16'h0, held;
   logic o7, oe7, o8, oe8, o9, oe9, w7, w8, w9, cs_n, rd_n, sck, chain;
   logic [31:0] q[$];
   int n_errors = 0, checks_done = 0, n_flag = 0;
   always #50 clk_i = ~clk_i;
   assign w7 = oe7 ? o7 : chain;
   assign w8 = oe8 ? o8 : 1'bz;
   assign w9 = oe9 ? o9 : sck;
   asrp_core u_dut (.clk_i, .rst_n_i, .result_i, .result_valid_i, .conv_busy_i, .port_select_i,
      .clock_source_select_i, .clock_invert_i, .output_coding_i, .cs_n_i(cs_n), .rd_n_i(rd_n),
      .parallel_bit_seven_i(w7), .parallel_bit_seven_o(o7), .parallel_bit_seven_oe_o(oe7),
      .parallel_bit_eight_o(o8), .parallel_bit_eight_oe_o(oe8), .parallel_bit_nine_i(w9),
      .parallel_bit_nine_o(o9), .parallel_bit_nine_oe_o(oe9), .incomplete_read_flag_o(rd_err),
      .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
      .avs_readdata, .avs_waitrequest, .irq_o);
   asrp_host u_host (.clk_i, .sdo_i(w8), .sck_i(w9), .inv_i(clock_invert_i),
      .int_i(port_select_i && !clock_source_select_i), .cs_n_o(cs_n), .rd_n_o(rd_n),
      .sclk_o(sck), .chain_o(chain));
   // ****************
   // helpers
   // ****************
   function automatic logic [31:0] xs();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [15:0] code(input logic [15:0] d);
      return output_coding_i ? d : {~d[15], d[14:0]};
   endfunction
   task automatic chk(input logic [31:0] got);
      logic [31:0] e;
      e = q.size() ? q.pop_front() : 32'hDEADBEEF;
      checks_done++;
      if (got !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask
   task automatic now(input logic [31:0] e, input logic [31:0] got);
      q.push_back(e);
      chk(got);
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
      avs_read <= 0;
      avs_write <= 0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      q.push_back(e);
      bus(0, a, 32'h0);
   endtask
   task automatic lat(input logic [15:0] d);
      @(posedge clk_i);
      result_i <= d;
      result_valid_i <= 1;
      @(posedge clk_i);
      result_valid_i <= 0;
      held = code(d);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk_i) if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata);
   always @(u_host.done_e) chk(u_host.word);
   always @(posedge clk_i) if (rd_err === 1'b1) n_flag++;
   initial begin
      #2000000;
      n_errors++;
      test_done();
   end
   // ****************
   // tests
   // ****************
   initial begin
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1;
      bus(1, `ASRP_OFS_MASK, 32'h7);
      rd(`ASRP_OFS_MASK, 32'h7);
      rd(4'h2, 32'h0);
      $display("test registers done");
      u_host.en(0, 0);
      v = xs();
      repeat (4) @(posedge clk_i);
      lat(v[15:0]);
      repeat (2) @(negedge clk_i);
      now({29'h0, v[9:7]}, {29'h0, w9, w8, w7});
      $display("test parallel done");
      u_host.en(1, 0);
      port_select_i <= 1;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_i);
         clock_invert_i <= k[0];
         output_coding_i <= k[1];
         v = xs();
         repeat (4) @(posedge clk_i);
         lat(v[15:0]);
         q.push_back({14'h0, held, v[16], v[16]});
         u_host.frame(18, v[16]);
      end
      @(negedge clk_i);
      now(32'h1, irq_o);
      rd(`ASRP_OFS_STATUS, 32'h5);
      bus(1, `ASRP_OFS_STATUS, 32'h7);
      rd(`ASRP_OFS_STATUS, 32'h0);
      @(negedge clk_i);
      now(32'h0, irq_o);
      $display("test external done");
      v = xs();
      fork
         u_host.frame(6, 0);
         begin
            #3000;
            lat(v[15:0]);
         end
      join
      now(32'h1, n_flag);
      bus(1, `ASRP_OFS_MASK, 32'h1);
      rd(`ASRP_OFS_STATUS, 32'h6);
      @(negedge clk_i);
      now(32'h0, irq_o);
      bus(1, `ASRP_OFS_MASK, 32'h7);
      @(negedge clk_i);
      now(32'h1, irq_o);
      rd(`ASRP_OFS_RESULT, {16'h0, held});
      bus(1, `ASRP_OFS_STATUS, 32'h7);
      $display("test abort done");
      clock_source_select_i <= 0;
      for (int k = 0; k < 2; k++) begin
         u_host.en(0, k[0]);
         repeat (4) @(posedge clk_i);
         v = xs();
         if (k == 0) begin
            q.push_back({16'h0, code(v[15:0])});
            lat(v[15:0]);
         end else begin
            q.push_back({16'h0, held});
            conv_busy_i <= 1;
         end
         @(u_host.done_e);
         conv_busy_i <= 0;
         u_host.en(1, 0);
      end
      // let the deselect pass the synchroniser before reading the sequencer state
      repeat (8) @(posedge clk_i);
      rd(`ASRP_OFS_STATE, 32'h10);
      $display("test internal done");
      test_done();
   end
endmodule
bind asrp_core asrp_chk u_chk (
   .clk_i(clk_i),
   .rst_n_i(rst_n_i),
   .result_valid_i(result_valid_i),
   .port_select_i(port_select_i),
   .clock_source_select_i(clock_source_select_i),
   .cs_n_i(cs_n_i),
   .rd_n_i(rd_n_i),
   .parallel_bit_seven_o(parallel_bit_seven_o),
   .parallel_bit_seven_oe_o(parallel_bit_seven_oe_o),
   .parallel_bit_eight_o(parallel_bit_eight_o),
   .parallel_bit_eight_oe_o(parallel_bit_eight_oe_o),
   .parallel_bit_nine_o(parallel_bit_nine_o),
   .parallel_bit_nine_oe_o(parallel_bit_nine_oe_o),
   .incomplete_read_flag_o(incomplete_read_flag_o),
   .avs_address(avs_address),
   .avs_read(avs_read),
   .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest),
   .irq_o(irq_o)
);
